//--- hw/els_timer.sv
// Tick-driven down counter, busy from load until the last tick
`timescale 1ns/1ps
`default_nettype none
module els_timer
  import els_pkg::*;
(
  els_tmr_if.timer bus // Load and status bundle
);
  logic [TW-1:0] cnt;
  logic          busy;

  assign bus.busy = busy;
  assign bus.done = busy & bus.tick & (cnt == TW'(1));

  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      cnt  <= '0;
      busy <= 1'b0;
    end else if (bus.load) begin
      // Reload wins so a retrigger restarts the full interval
      cnt  <= bus.val;
      busy <= (bus.val != '0);
    end else if (bus.done) begin
      cnt  <= '0;
      busy <= 1'b0;
    end else if (busy && bus.tick) begin
      cnt  <= cnt - TW'(1);
    end
  end
endmodule
`default_nettype wire

//--- hw/els_top.sv
// External-control laser sequencer: supply, schedule, start, emission, end and monitor
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module els_top
  import els_pkg::*;
#(
  parameter int TICK_CYCLES      = TICK_CYC,
  parameter int SUPPLY_TMO_TICKS = int'(most_ticks(SUPPLY_MAX_US)),
  parameter int PREP_TMO_TICKS   = int'(most_ticks(PREP_MAX_US)),
  parameter int HEAT_ACC_TICKS   = int'(least_ticks(HEAT_ACC_US))
) (
  input  wire logic          i_ref_clk,          // 25 MHz clock
  input  wire logic          i_rst,              // Async reset, active high
  input  wire logic [AW-1:0] i_addr,             // Register byte address
  input  wire logic [DW-1:0] i_wdata,            // Write data
  input  wire logic          i_wr,               // Write strobe
  input  wire logic          i_rd,               // Read strobe
  output var  logic [DW-1:0] o_rdata,            // Read data, cycle after i_rd
  input  wire logic          i_ext_sel,          // Pin: external control
  input  wire logic          i_start,            // Pin: laser start
  input  wire logic [SW-1:0] i_sched,            // Pins: schedule, 0 = none
  input  wire logic          i_supply_ok,        // Pin: supply started
  input  wire logic          i_prep_ok,          // Pin: preparation done
  input  wire logic [TW-1:0] i_energy,           // Measured energy, same clock
  output var  logic          o_front_panel_mode, // Panel has control
  output var  logic          o_supply_en,        // Supply contactor drive
  output var  logic          o_supply_on,        // Diode supply running
  output var  logic [SW-1:0] o_sched,            // Established schedule
  output var  logic          o_sched_valid,      // A schedule is established
  output var  logic          o_ready,            // Output ready
  output var  logic          o_emit_b1,          // Emission, branch 1
  output var  logic          o_emit_b2,          // Emission, branch 2
  output var  logic          o_end,              // End pulse
  output var  logic          o_mon_high,         // Energy above upper limit
  output var  logic          o_mon_low           // Energy below lower limit
);

  ////////////////////////////////////////
  // Pin synchronisers

  localparam int PINS = SW + 4;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_ext_sel, i_start, i_supply_ok, i_prep_ok, i_sched};
      pin_sync <= pin_meta;
    end
  end

  wire logic          ext_s    = pin_sync[SW+3];
  wire logic          start_s  = pin_sync[SW+2];
  wire logic          sup_ok_s = pin_sync[SW+1];
  wire logic          prep_s   = pin_sync[SW];
  wire logic [SW-1:0] sched_s  = pin_sync[SW-1:0];

  ////////////////////////////////////////
  // Time base

  logic [TW-1:0] tick_cnt;
  wire  logic    tick = (tick_cnt == '0);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= TW'(TICK_CYCLES - 1); // RQ19
    end else begin
      tick_cnt <= tick_cnt - TW'(1);
    end
  end

  els_tmr_if u_tif [NTMR] (.clk(i_ref_clk), .rst(i_rst));

  genvar g;
  generate
    for (g = 0; g < NTMR; g++) begin : g_tmr
      assign u_tif[g].tick = tick;
      els_timer u_tmr (.bus(u_tif[g])); // RQ19
    end
  endgenerate

  ////////////////////////////////////////
  // Register file

  logic [CTRL_W-1:0] ctrl;
  logic [TW-1:0]     emit_time;
  logic [TW-1:0]     gap_time;
  logic [TW-1:0]     upper;
  logic [TW-1:0]     lower;
  logic [TW-1:0]     heat_map;
  logic [TW-1:0]     energy;

  wire logic wr_ctrl  = i_wr && (i_addr == A_CTRL);
  wire logic wr_emit  = i_wr && (i_addr == A_EMIT);
  wire logic wr_gap   = i_wr && (i_addr == A_GAP);
  wire logic wr_upper = i_wr && (i_addr == A_UPPER);
  wire logic wr_lower = i_wr && (i_addr == A_LOWER);
  wire logic wr_heat  = i_wr && (i_addr == A_HEAT);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl      <= CTRL_RST;
      emit_time <= EMIT_RST;
      gap_time  <= GAP_RST;
      upper     <= UPPER_RST;
      lower     <= LOWER_RST;
      heat_map  <= '0;
    end else begin
      if (wr_ctrl)  ctrl      <= i_wdata[CTRL_W-1:0];
      if (wr_emit)  emit_time <= i_wdata[TW-1:0];
      if (wr_gap)   gap_time  <= i_wdata[TW-1:0];
      if (wr_upper) upper     <= i_wdata[TW-1:0];
      if (wr_lower) lower     <= i_wdata[TW-1:0];
      if (wr_heat)  heat_map  <= i_wdata[TW-1:0];
    end
  end

  wire logic       supply_en = ctrl[C_SUPPLY];
  wire logic       two_br    = ctrl[C_TWO];
  wire logic       rep_mode  = ctrl[C_REP];
  wire logic       fast_mon  = ctrl[C_FAST];
  wire logic       heat_en   = ctrl[C_HEAT];
  wire logic [2:0] acc_sel   = ctrl[C_ACC_LO +: 3];
  wire logic [1:0] pw_sel    = ctrl[C_PW_LO +: 2];

  // Unlisted codes fall back to the defaults
  wire logic [TW-1:0] acc_ticks =
    (acc_sel == 3'h1) ? least_ticks(ACC_US[1]) :
    (acc_sel == 3'h2) ? least_ticks(ACC_US[2]) :
    (acc_sel == 3'h3) ? least_ticks(ACC_US[3]) :
    (acc_sel == 3'h4) ? least_ticks(ACC_US[4]) :
    (acc_sel == 3'h5) ? least_ticks(ACC_US[5]) :
                        least_ticks(ACC_US[0]); // RQ6
  wire logic [TW-1:0] pw_ticks =
    (pw_sel == 2'h1) ? least_ticks(PW_US[1]) :
    (pw_sel == 2'h2) ? least_ticks(PW_US[2]) :
                       least_ticks(PW_US[0]); // RQ13
  wire logic [TW-1:0] mon_ticks =
    (rep_mode && fast_mon) ? least_ticks(MON_FAST_US) : pw_ticks; // RQ16
  // A zero time would leave the sequencer waiting forever
  wire logic [TW-1:0] emit_ticks = (emit_time == '0) ? TW'(1) : emit_time;
  wire logic [TW-1:0] gap_ticks  = (gap_time == '0) ? TW'(1) : gap_time;

  ////////////////////////////////////////
  // Schedule filter

  logic [SW-1:0] sched_cand;
  logic [SW-1:0] sched_est;
  logic          sched_valid;

  wire logic sched_chg  = ext_s && (sched_s != sched_cand);
  wire logic heat_chg   = heat_en && (heat_map[sched_s] != heat_map[sched_est]);
  wire logic sched_take = u_tif[T_SCH].done;

  // Any new pattern restarts the wait, so short glitches never establish
  assign u_tif[T_SCH].load = sched_chg; // RQ20
  assign u_tif[T_SCH].val  = heat_chg ? TW'(HEAT_ACC_TICKS) : acc_ticks; // RQ5

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sched_cand  <= '0;
      sched_est   <= '0;
      sched_valid <= 1'b0;
    end else begin
      if (sched_chg) sched_cand <= sched_s;
      if (sched_take && !sched_chg) begin
        sched_est   <= sched_cand; // RQ4
        sched_valid <= (sched_cand != '0);
      end
    end
  end

  ////////////////////////////////////////
  // Sequencer

  els_state_t       state;
  els_state_t       next_state;
  logic             seq_load;
  logic [TW-1:0]    seq_val;
  logic [OSC_W-1:0] osc_cnt;

  wire logic seq_done = u_tif[T_SEQ].done;
  wire logic osc_done = (state == ST_OSC) && (osc_cnt == '0);
  // Start opening or timer expiry finishes the output
  wire logic finish   = (state == ST_EMIT) && (seq_done || !start_s); // RQ18
  wire logic running  = (state != ST_OFF) && (state != ST_SUPPLY);
  wire logic ext_busy = (state == ST_ACCEPT) || (state == ST_OSC) ||
                        (state == ST_EMIT) || (state == ST_GAP) || (state == ST_HOLD);

  always_comb begin
    next_state = state;
    seq_load   = 1'b0;
    seq_val    = '0;
    case (state)
      ST_OFF: begin
        if (supply_en) begin
          next_state = ST_SUPPLY;
          seq_load   = 1'b1;
          seq_val    = TW'(SUPPLY_TMO_TICKS); // RQ3
        end
      end
      ST_SUPPLY: begin
        if (sup_ok_s || seq_done) begin
          next_state = ST_IDLE; // RQ3
        end
      end
      ST_IDLE: begin
        if (sched_valid && ext_s) begin
          next_state = ST_PREP;
          seq_load   = 1'b1;
          seq_val    = TW'(PREP_TMO_TICKS); // RQ7
        end
      end
      ST_PREP: begin
        if (prep_s || seq_done) begin
          next_state = ST_READY; // RQ7
        end
      end
      ST_READY: begin
        if (start_s) begin
          next_state = ST_ACCEPT;
          seq_load   = 1'b1;
          seq_val    = acc_ticks; // RQ9
        end
      end
      ST_ACCEPT: begin
        if (!start_s) begin
          next_state = ST_READY; // RQ20
        end else if (seq_done) begin
          next_state = ST_OSC; // RQ9
        end
      end
      ST_OSC: begin
        if (!start_s) begin
          next_state = ST_READY;
        end else if (osc_done) begin
          next_state = ST_EMIT; // RQ10
          seq_load   = 1'b1;
          seq_val    = emit_ticks;
        end
      end
      ST_EMIT: begin
        if (finish) begin
          if (rep_mode && start_s) begin
            next_state = ST_GAP; // RQ15
            seq_load   = 1'b1;
            seq_val    = gap_ticks;
          end else begin
            next_state = ST_HOLD;
          end
        end
      end
      ST_GAP: begin
        if (!start_s) begin
          next_state = ST_READY;
        end else if (seq_done) begin
          next_state = ST_EMIT; // RQ15
          seq_load   = 1'b1;
          seq_val    = emit_ticks;
        end
      end
      ST_HOLD: begin
        // One output per closure in single mode
        if (!start_s) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // Panel mode or a lost schedule drops back before any new output
    if ((!ext_s || !sched_valid) && (state == ST_READY || ext_busy) && !finish) begin
      next_state = ST_IDLE; // RQ17
      seq_load   = 1'b0;
    end
    if (!supply_en) begin
      next_state = ST_OFF;
      seq_load   = 1'b0;
    end
  end

  assign u_tif[T_SEQ].load = seq_load;
  assign u_tif[T_SEQ].val  = seq_val;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state   <= ST_OFF;
      osc_cnt <= '0;
    end else begin
      state   <= next_state;
      osc_cnt <= (state == ST_ACCEPT) ? OSC_W'(OSC_DLY_CYC - 1) :
                 (osc_cnt != '0) ? osc_cnt - OSC_W'(1) : osc_cnt; // RQ10
    end
  end

  ////////////////////////////////////////
  // End and monitor judgement

  wire logic e_high = (i_energy > upper);
  wire logic e_low  = (i_energy < lower);

  assign u_tif[T_END].load = finish; // RQ11
  assign u_tif[T_END].val  = pw_ticks; // RQ13
  assign u_tif[T_HI].load  = finish && e_high; // RQ12
  assign u_tif[T_HI].val   = mon_ticks; // RQ16
  assign u_tif[T_LO].load  = finish && e_low; // RQ12
  assign u_tif[T_LO].val   = mon_ticks; // RQ16

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      energy <= '0;
    end else if (finish) begin
      energy <= i_energy;
    end
  end

  ////////////////////////////////////////
  // Outputs

  wire logic next_emit = (next_state == ST_EMIT);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_emit_b1 <= 1'b0;
      o_emit_b2 <= 1'b0;
      o_ready   <= 1'b0;
      o_supply_on <= 1'b0;
      o_supply_en <= 1'b0;
      o_front_panel_mode <= 1'b1;
    end else begin
      o_emit_b1 <= next_emit;
      o_emit_b2 <= next_emit && two_br; // RQ14
      o_ready   <= (next_state == ST_READY) || (next_state == ST_ACCEPT);
      o_supply_on <= (next_state != ST_OFF) && (next_state != ST_SUPPLY); // RQ1
      o_supply_en <= (next_state != ST_OFF);
      o_front_panel_mode <= !ext_s; // RQ17
    end
  end

  assign o_sched       = sched_est;
  assign o_sched_valid = sched_valid;
  assign o_end         = u_tif[T_END].busy;
  assign o_mon_high    = u_tif[T_HI].busy;
  assign o_mon_low     = u_tif[T_LO].busy;

  ////////////////////////////////////////
  // Read port

  wire logic [DW-1:0] status = DW'({4'(state), sched_est, o_mon_low, o_mon_high,
    o_end, o_front_panel_mode, o_emit_b1, o_ready, sched_valid, running});

  wire logic [DW-1:0] rd_mux =
    (i_addr == A_CTRL)   ? DW'(ctrl) :
    (i_addr == A_STATUS) ? status :
    (i_addr == A_EMIT)   ? DW'(emit_time) :
    (i_addr == A_GAP)    ? DW'(gap_time) :
    (i_addr == A_UPPER)  ? DW'(upper) :
    (i_addr == A_LOWER)  ? DW'(lower) :
    (i_addr == A_HEAT)   ? DW'(heat_map) :
    (i_addr == A_ENERGY) ? DW'(energy) : '0;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

endmodule
`default_nettype wire

//--- inc/els_pkg.sv
// Constants, register map and state type of the laser sequencer
//
// Summary of operation
// [RQ1] Supply-on rises once the diode supply runs; it does not mean emission.
// [RQ2] Controller waits 2 ms or more after selecting external control.
// [RQ3] Diode supply start phase ends within 5 s; supply then counts as running.
// [RQ4] A schedule becomes established only after being held for the acceptance time.
// [RQ5] With heat control on and heat setting changing, establishment takes about 200 ms.
// [RQ6] Acceptance time defaults to 4 ms; 0.1, 1, 2, 8 or 16 ms selectable.
// [RQ7] Output-ready rises within 1 s after preparation begins.
// [RQ8] Controller allows 150 ms of shutter travel before laser start.
// [RQ9] Laser start is taken only after staying asserted for the acceptance time.
// [RQ10] Oscillation begins 50 to 100 us after the start acceptance time.
// [RQ11] Each finished output is followed by an end pulse.
// [RQ12] After each output, high and low outputs judge energy against limits.
// [RQ13] End and judgement pulses last 20 ms, or 30 or 40 ms by setting.
// [RQ14] Two-branch mode drives both branch outputs together on one start.
// [RQ15] Repeated mode emits pulse trains at 50 pulses per second or faster.
// [RQ16] At high rates a monitor error pulse lasts at least 1 ms.
// [RQ17] One input selects front-front_panel_mode (open) or external control (closed).
// [RQ18] The controller closes laser start to emit and opens it to stop.
// [RQ19] All intervals count a fixed sub-millisecond tick; reset clears them. The oscillation delay counts clock cycles instead.
// [RQ20] Input changes shorter than the acceptance time are discarded.
package els_pkg;

  localparam int CLK_NS   = 40;
  localparam int TICK_US  = 100;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam int TW       = 16;
  localparam int SW       = 4;
  localparam int AW       = 8;
  localparam int DW       = 32;

  localparam int SUPPLY_MAX_US = 5000000;
  localparam int PREP_MAX_US   = 1000000;
  localparam int HEAT_ACC_US   = 200000;
  localparam int ACC_US [6]    = '{4000, 100, 1000, 2000, 8000, 16000};
  localparam int PW_US  [3]    = '{20000, 30000, 40000};
  localparam int MON_FAST_US   = 1000;
  localparam int OSC_MIN_US    = 50;
  localparam int OSC_MAX_US    = 100;
  localparam int OSC_DLY_CYC   = ((OSC_MIN_US + OSC_MAX_US) / 2) * 1000 / CLK_NS;
  localparam int OSC_W         = 12;
  localparam int NTMR          = 5;
  localparam int T_SEQ         = 0;
  localparam int T_SCH         = 1;
  localparam int T_END         = 2;
  localparam int T_HI          = 3;
  localparam int T_LO          = 4;

  // Least time: an extra tick covers the unknown phase of the tick at load
  function automatic logic [TW-1:0] least_ticks(input int us);
    return TW'((us + TICK_US - 1) / TICK_US + 1);
  endfunction

  function automatic logic [TW-1:0] most_ticks(input int us);
    return (us < TICK_US) ? TW'(1) : TW'(us / TICK_US);
  endfunction

  localparam logic [AW-1:0] A_CTRL   = 8'h00;
  localparam logic [AW-1:0] A_STATUS = 8'h04;
  localparam logic [AW-1:0] A_EMIT   = 8'h08;
  localparam logic [AW-1:0] A_GAP    = 8'h0c;
  localparam logic [AW-1:0] A_UPPER  = 8'h10;
  localparam logic [AW-1:0] A_LOWER  = 8'h14;
  localparam logic [AW-1:0] A_HEAT   = 8'h18;
  localparam logic [AW-1:0] A_ENERGY = 8'h1c;

  localparam int C_SUPPLY = 0;
  localparam int C_TWO    = 1;
  localparam int C_REP    = 2;
  localparam int C_FAST   = 3;
  localparam int C_HEAT   = 4;
  localparam int C_ACC_LO = 5;
  localparam int C_PW_LO  = 8;
  localparam int CTRL_W   = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
  localparam logic [TW-1:0]     EMIT_RST  = 16'h0064;
  localparam logic [TW-1:0]     GAP_RST   = 16'h0064;
  localparam logic [TW-1:0]     UPPER_RST = 16'hffff;
  localparam logic [TW-1:0]     LOWER_RST = 16'h0000;

  typedef enum logic [3:0] {
    ST_OFF, ST_SUPPLY, ST_IDLE, ST_PREP, ST_READY,
    ST_ACCEPT, ST_OSC, ST_EMIT, ST_GAP, ST_HOLD
  } els_state_t;

endpackage

//--- inc/els_tmr_if.sv
// Load/tick/busy bundle between the sequencer and one tick timer
`timescale 1ns/1ps
`default_nettype none
interface els_tmr_if
  import els_pkg::*;
(
  input wire logic clk, // Block clock
  input wire logic rst  // Asynchronous reset, active high
);
  logic          tick;
  logic          load;
  logic [TW-1:0] val;
  logic          busy;
  logic          done;
  modport timer (input clk, rst, tick, load, val, output busy, done);
  modport user  (output tick, load, val, input busy, done);
endinterface
`default_nettype wire

//--- sim/els_plc.sv
// Controller model driving the sequencer's discrete control pins
`timescale 1ns/1ps
`default_nettype none
module els_plc
  import els_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic          i_ref_clk,   // Clock
  output var  logic          o_ext_sel,   // External control
  output var  logic          o_start,     // Laser start
  output var  logic [SW-1:0] o_sched,     // Schedule number
  output var  logic          o_supply_ok, // Supply started
  output var  logic          o_prep_ok    // Preparation done
);
  initial begin
    o_ext_sel   = 1'b0;
    o_start     = 1'b0;
    o_sched     = '0;
    o_supply_ok = 1'b0;
    o_prep_ok   = 1'b0;
  end
  // Waits scale with the bench's tick
  task automatic hold_us(input int us);
    repeat (us / TICK_US * TICK_CYCLES) @(posedge i_ref_clk);
  endtask
  task automatic select(input logic ext);
    @(posedge i_ref_clk);
    o_ext_sel <= ext;
    hold_us(2000);
  endtask
  task automatic shutter();
    hold_us(150000);
  endtask
  task automatic set_start(input logic on);
    @(posedge i_ref_clk);
    o_start <= on;
  endtask
  task automatic set_sched(input logic [SW-1:0] s);
    @(posedge i_ref_clk);
    o_sched <= s;
  endtask
  task automatic set_ok(input logic sup, input logic prep);
    @(posedge i_ref_clk);
    o_supply_ok <= sup;
    o_prep_ok   <= prep;
  endtask
endmodule
`default_nettype wire

//--- sim/els_top_sva.sv
// Port-level assertions for the laser sequencer top
`timescale 1ns/1ps
`default_nettype none
module els_top_sva
  import els_pkg::*;
#(
  parameter int TICK_CYCLES      = TICK_CYC,
  parameter int SUPPLY_TMO_TICKS = int'(most_ticks(SUPPLY_MAX_US))
) (
  input wire logic          i_ref_clk,          // Clock
  input wire logic          i_rst,              // Reset
  input wire logic          i_start,            // Start pin
  input wire logic [SW-1:0] i_sched,            // Schedule pins
  input wire logic          o_front_panel_mode, // Panel mode
  input wire logic          o_supply_en,        // Supply drive
  input wire logic          o_supply_on,        // Supply running
  input wire logic [SW-1:0] o_sched,            // Schedule
  input wire logic          o_sched_valid,      // Schedule valid
  input wire logic          o_ready,            // Ready
  input wire logic          o_emit_b1,          // Branch 1
  input wire logic          o_emit_b2,          // Branch 2
  input wire logic          o_end,              // End pulse
  input wire logic          o_mon_high,         // High judgement
  input wire logic          o_mon_low           // Low judgement
);
  localparam int END_MIN = 200 * TICK_CYCLES;
  localparam int MON_MIN = 10 * TICK_CYCLES;
  localparam int SUP_MAX = (SUPPLY_TMO_TICKS + 1) * TICK_CYCLES + 4;
  int start_cyc, end_cyc, mon_cyc, sup_cyc;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
////////////////////////////////////////
  // Level run lengths; long pulses are too long to unroll
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      start_cyc <= 0;
      end_cyc   <= 0;
      mon_cyc   <= 0;
      sup_cyc   <= 0;
    end else begin
      start_cyc <= i_start ? start_cyc + 1 : 0;
      end_cyc   <= o_end ? end_cyc + 1 : 0;
      mon_cyc   <= o_mon_high ? mon_cyc + 1 : 0;
      sup_cyc   <= (o_supply_en && !o_supply_on) ? sup_cyc + 1 : 0;
    end
  end
////////////////////////////////////////
  a_start_held: assert property ($rose(o_emit_b1) |->
    start_cyc >= OSC_DLY_CYC + TICK_CYCLES / 2) else $error("start held too briefly");
  a_end_follows: assert property ($fell(o_emit_b1) |-> o_end) else $error("no end pulse");
  a_mon_at_end: assert property ($rose(o_mon_high) || $rose(o_mon_low) |->
    $fell(o_emit_b1)) else $error("judgement off output end");
  a_end_width: assert property ($fell(o_end) |-> end_cyc >= END_MIN)
    else $error("end pulse too short");
  a_mon_min_width: assert property ($fell(o_mon_high) |-> mon_cyc >= MON_MIN)
    else $error("monitor pulse too short");
  a_branch_pair: assert property ($rose(o_emit_b2) |-> $rose(o_emit_b1))
    else $error("branch 2 without branch 1");
  a_supply_on_en: assert property (o_supply_on |-> o_supply_en)
    else $error("supply on without drive");
  a_supply_bound: assert property (sup_cyc <= SUP_MAX)
    else $error("supply start phase overran");
  a_sched_filter: assert property ($changed(o_sched) && o_sched != '0 |->
    $past(i_sched, 8) == o_sched) else $error("short schedule taken");
  a_ready_cause: assert property (o_ready |-> o_supply_on && o_sched_valid)
    else $error("ready without schedule");
  a_panel_quiet: assert property (o_front_panel_mode [*4] |-> !o_ready && !o_emit_b1)
    else $error("pins acted on in panel mode");
  c_two: cover property ($rose(o_emit_b2));
  c_high: cover property ($rose(o_mon_high));
  c_low: cover property ($rose(o_mon_low));
endmodule
`default_nettype wire

//--- sim/test_els_top.sv
// Self-checking bench for the laser sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin \
  n_compared++; \
  if ((got) !== (want)) begin \
    err_count++; \
    $display("wrong value at %0t: %0h vs %0h", $time, got, want); \
  end \
end
`define WAITC(c, n) begin cyc = 0; #1; \
  while (!(c) && cyc < (n)) begin @(posedge clk); #1; cyc++; end end
module test_els_top
  import els_pkg::*;
;
  localparam int TC = 10;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic          wr_s = 1'b0;
  logic          rd_s = 1'b0;
  logic [TW-1:0] energy = '0;
  logic [DW-1:0] rdata;
  logic [SW-1:0] sched_pin, sched;
  logic          ext_sel, start, supply_ok, prep_ok, panel, sup_en, sup_on, valid;
  logic          ready, b1, b2, endp, hi, lo, pb;
  int            err_count = 0;
  int            n_compared = 0;
  int            cycles = 0;
  int            cyc, n, lo_b, hi_b, p;
  always #20 clk = ~clk;
  els_plc #(.TICK_CYCLES(TC)) els_plc_inst (.i_ref_clk(clk), .o_ext_sel(ext_sel),
    .o_start(start), .o_sched(sched_pin), .o_supply_ok(supply_ok), .o_prep_ok(prep_ok));
  els_top #(.TICK_CYCLES(TC), .SUPPLY_TMO_TICKS(20), .PREP_TMO_TICKS(10),
    .HEAT_ACC_TICKS(60)) els_top_inst (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_ext_sel(ext_sel),
    .i_start(start), .i_sched(sched_pin), .i_supply_ok(supply_ok), .i_prep_ok(prep_ok),
    .i_energy(energy), .o_front_panel_mode(panel), .o_supply_en(sup_en),
    .o_supply_on(sup_on), .o_sched(sched), .o_sched_valid(valid), .o_ready(ready),
    .o_emit_b1(b1), .o_emit_b2(b2), .o_end(endp), .o_mon_high(hi), .o_mon_low(lo));
////////////////////////////////////////
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] want);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK(rdata, want)
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Ceiling well above the ~56k-cycle run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      wrap_up();
    end
  end
////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({panel, sup_en, sup_on, b1, endp}, 5'b10000)
    rd(A_CTRL, 32'h0);
    rd(A_EMIT, 32'h64);
    rd(A_GAP, 32'h64);
    rd(A_UPPER, 32'hffff);
    rd(A_LOWER, 32'h0);
    rd(8'h20, 32'h0);
    wr(A_CTRL, 32'h1);
    `WAITC(sup_on, 400)
    `CHK(cyc >= 185 && cyc <= 215, 1'b1)
    wr(A_UPPER, 32'h100);
    wr(A_LOWER, 32'h80);
    wr(A_EMIT, 32'h5);
    wr(A_HEAT, 32'h40);
    els_plc_inst.select(1'b1);
    els_plc_inst.set_sched(4'h3);
    idle(200);
    els_plc_inst.set_sched(4'h0);
    idle(600);
    `CHK(valid, 1'b0)
    els_plc_inst.set_sched(4'h5);
    `WAITC(valid, 700)
    `CHK(cyc >= 396 && cyc <= 420, 1'b1)
    `CHK(sched, 4'h5)
    `WAITC(ready, 200)
    `CHK(cyc >= 90 && cyc <= 120, 1'b1)
    wr(A_CTRL, 32'h11);
    els_plc_inst.set_sched(4'h6);
    `WAITC(sched == 4'h6, 900)
    `CHK(cyc >= 585 && cyc <= 620, 1'b1)
    els_plc_inst.shutter();
    els_plc_inst.set_start(1'b1);
    idle(200);
    els_plc_inst.set_start(1'b0);
    idle(2300);
    `CHK({b1, endp, ready}, 3'b001)
    for (int i = 0; i < 6; i++) begin
      wr(A_CTRL, 32'h11 | (i << 5) | ((i % 3) << 8) | ((i == 2) << 1));
      energy <= (i == 0) ? 16'h200 : (i == 1) ? 16'h10 : 16'hc0;
      els_plc_inst.set_start(1'b1);
      `WAITC(b1, 3800)
      lo_b = ACC_US[i] * TC / 100 + OSC_DLY_CYC - 2;
      hi_b = ((ACC_US[i] + 99) / 100 + 1) * TC + OSC_DLY_CYC + 8;
      `CHK(cyc >= lo_b && cyc <= hi_b, 1'b1)
      `CHK(b2, i == 2)
      `WAITC(!b1, 100)
      `CHK({endp, hi, lo}, (i == 0) ? 3'b110 : (i == 1) ? 3'b101 : 3'b100)
      els_plc_inst.set_start(1'b0);
      p = PW_US[i % 3] / 100 + 1;
      `WAITC(!endp, 4100)
      `CHK(cyc >= (p - 1) * TC - 8 && cyc <= p * TC + 4, 1'b1)
    end
    rd(A_ENERGY, 32'hc0);
    wr(A_CTRL, 32'h3d);
    wr(A_GAP, 32'h5);
    energy <= 16'h200;
    els_plc_inst.set_start(1'b1);
    `WAITC(b1, 2200)
    pb = 1'b1;
    n = 0;
    repeat (1000) begin
      @(posedge clk);
      #1;
      if (b1 && !pb) n++;
      pb = b1;
    end
    `CHK(n >= 8 && n <= 10, 1'b1)
    els_plc_inst.set_start(1'b0);
    `WAITC(!b1, 100)
    `WAITC(!hi, 400)
    `CHK(cyc <= 12 * TC, 1'b1)
    els_plc_inst.select(1'b0);
    `CHK({panel, ready, b1}, 3'b100)
    wr(A_CTRL, 32'h0);
    idle(5);
    `CHK({sup_en, sup_on}, 2'b00)
    els_plc_inst.set_ok(1'b1, 1'b1);
    wr(A_CTRL, 32'h21);
    `WAITC(sup_on, 100)
    `CHK(cyc < 10, 1'b1)
    els_plc_inst.select(1'b1);
    `CHK(ready, 1'b1)
    wrap_up();
  end
endmodule
bind els_top els_top_sva #(.TICK_CYCLES(TICK_CYCLES), .SUPPLY_TMO_TICKS(SUPPLY_TMO_TICKS))
  els_top_sva_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(i_start),
  .i_sched(i_sched), .o_front_panel_mode(o_front_panel_mode), .o_supply_en(o_supply_en),
  .o_supply_on(o_supply_on), .o_sched(o_sched), .o_sched_valid(o_sched_valid),
  .o_ready(o_ready), .o_emit_b1(o_emit_b1), .o_emit_b2(o_emit_b2), .o_end(o_end),
  .o_mon_high(o_mon_high), .o_mon_low(o_mon_low));
`default_nettype wire
